// ---- include/lam_pkg.sv ----
package lam_pkg;
  localparam int NLINK = 4;
  localparam int NTERM = 4;
  localparam int NDL = 8;
  localparam int LW = 2;
  localparam int TW = 2;
  localparam int DW = 3;
  localparam int PCW = 14;
  localparam int CW = 27;
  localparam int CLK_HZ = 50_000_000;
  localparam int RETRY_MS = 2000;
  localparam int RETRY_CYC = RETRY_MS * (CLK_HZ / 1000);
  typedef enum logic [1:0] {S_IDLE, S_WAIT, S_ALIGN} st_t;
  typedef enum logic [1:0] {LK_INACT, LK_ACTIVE, LK_FAILED} lk_t;
  typedef enum logic {MSG_ORDER, MSG_ACK} msg_t;
  typedef enum logic [1:0] {RES_OK, RES_ALT, RES_NOALT} res_t;
endpackage

// ---- src/link_alloc_mgr.sv ----
`timescale 1ns/1ps
`default_nettype none
module link_alloc_mgr #(
  parameter int unsigned RETRY_CYC = lam_pkg::RETRY_CYC
) (
  input  wire logic                                 clk_i,
  input  wire logic                                 rst_n_i,
  input  wire logic [lam_pkg::PCW-1:0]              own_pc_i,
  input  wire logic [lam_pkg::PCW-1:0]              remote_pc_i,
  input  wire logic [lam_pkg::LW:0]                 active_target_i,
  input  wire logic [lam_pkg::TW:0]                 min_terms_i,
  input  wire logic                                 setact_i,
  input  wire logic [lam_pkg::NLINK*lam_pkg::DW-1:0] predef_dl_i,
  input  wire logic [lam_pkg::NLINK-1:0]            link_fail_i,
  input  wire logic [lam_pkg::NLINK-1:0]            align_ok_i,
  input  wire logic [lam_pkg::NLINK-1:0]            align_fail_i,
  input  wire logic [lam_pkg::NLINK-1:0]            traffic_i,
  input  wire logic [lam_pkg::NTERM-1:0]            term_ok_i,
  input  wire logic [lam_pkg::NDL-1:0]              dl_usable_i,
  input  wire logic                                 rx_ord_v_i,
  input  wire logic [lam_pkg::LW-1:0]               rx_ord_link_i,
  input  wire logic [lam_pkg::DW-1:0]               rx_ord_dl_i,
  input  wire logic                                 rx_ack_v_i,
  input  wire logic [lam_pkg::LW-1:0]               rx_ack_link_i,
  input  wire lam_pkg::res_t                        rx_ack_res_i,
  input  wire logic                                 donate_req_i,
  input  wire logic                                 donate_done_i,
  output logic                                      tx_v_o,
  output lam_pkg::msg_t                             tx_kind_o,
  output logic [lam_pkg::PCW-1:0]                   tx_dpc_o,
  output logic [lam_pkg::PCW-1:0]                   tx_opc_o,
  output logic [lam_pkg::LW-1:0]                    tx_link_o,
  output logic [lam_pkg::DW-1:0]                    tx_dl_o,
  output lam_pkg::res_t                             tx_res_o,
  output logic [lam_pkg::NLINK-1:0]                 align_start_o,
  output logic [lam_pkg::NLINK-1:0]                 link_active_o,
  output logic [lam_pkg::NDL-1:0]                   dl_seized_o,
  output logic                                      donate_gnt_o,
  output logic [lam_pkg::TW-1:0]                    donate_term_o
);
  localparam int NL = lam_pkg::NLINK;
  localparam int LW = lam_pkg::LW;
  localparam int TW = lam_pkg::TW;
  localparam int DW = lam_pkg::DW;

  lam_pkg::st_t    st_r, st_nxt;
  lam_pkg::lk_t    lst_r [NL];
  lam_pkg::lk_t    lst_nxt [NL];
  logic [TW-1:0]   lterm_r [NL];
  logic [TW-1:0]   lterm_nxt [NL];
  logic [DW-1:0]   ldl_r [NL];
  logic [DW-1:0]   ldl_nxt [NL];
  logic [NL-1:0]   ltv_r, ltv_nxt, ldv_r, ldv_nxt, fp_r, fp_nxt;
  logic [LW-1:0]   cur_r, cur_nxt, nxt_r, nxt_nxt;
  logic            tried_r, tried_nxt, setact_r, setact_nxt;
  logic [lam_pkg::NTERM-1:0] lent_r, lent_nxt;
  logic [lam_pkg::CW-1:0]    tmr_r, tmr_nxt;
  logic            tx_v_nxt, gnt_nxt;
  lam_pkg::msg_t   tx_kind_nxt;
  lam_pkg::res_t   tx_res_nxt;
  logic [LW-1:0]   tx_link_nxt;
  logic [DW-1:0]   tx_dl_nxt;
  logic [TW-1:0]   dterm_nxt;
  logic [NL-1:0]   align_nxt;

  logic [lam_pkg::NDL-1:0]   dl_used;
  logic [lam_pkg::NTERM-1:0] term_used;
  logic [LW:0]     n_act;
  logic [TW:0]     n_trm;
  logic            it_v, ft_v, fd_v, lo_v, na_v, fp_v;
  logic [TW-1:0]   it_t;
  logic [LW-1:0]   ft_l, lo_l, na_l, fp_l;
  logic [DW-1:0]   fd_d;

  always_comb
  begin
    dl_used = '0;
    term_used = lent_r;
    n_act = '0;
    n_trm = '0;
    it_v = 1'b0; it_t = '0; ft_v = 1'b0; ft_l = '0;
    fd_v = 1'b0; fd_d = '0; lo_v = 1'b0; lo_l = '0;
    na_v = 1'b0; na_l = '0; fp_v = 1'b0; fp_l = '0;
    for (int i = 0; i < NL; i++)
    begin
      if (ldv_r[i]) dl_used[ldl_r[i]] = 1'b1;
      if (ltv_r[i])
      begin
        term_used[lterm_r[i]] = 1'b1;
        n_trm = n_trm + 1'b1;
      end
      if (lst_r[i] == lam_pkg::LK_ACTIVE) n_act = n_act + 1'b1;
    end
    // descending scans so the lowest index wins the pick; the inactive-link scan counts from nxt_r
    for (int t = lam_pkg::NTERM - 1; t >= 0; t--)
      if (!term_used[t] && term_ok_i[t])
      begin
        it_v = 1'b1;
        it_t = TW'(t);
      end
    for (int d = lam_pkg::NDL - 1; d >= 0; d--)
      if (dl_usable_i[d] && !dl_used[d])
      begin
        fd_v = 1'b1;
        fd_d = DW'(d);
      end
    for (int l = NL - 1; l >= 0; l--)
    begin
      if (lst_r[l] == lam_pkg::LK_FAILED && ltv_r[l])
      begin
        ft_v = 1'b1;
        ft_l = LW'(l);
      end
      if (fp_r[l])
      begin
        fp_v = 1'b1;
        fp_l = LW'(l);
      end
      if (lst_r[LW'(nxt_r + LW'(l))] == lam_pkg::LK_INACT)
      begin
        na_v = 1'b1;
        na_l = LW'(nxt_r + LW'(l));
      end
    end
    // ascending: the highest index is the lowest priority
    for (int l = 0; l < NL; l++)
      if (lst_r[l] == lam_pkg::LK_ACTIVE)
      begin
        lo_v = 1'b1;
        lo_l = LW'(l);
      end
    // a busy lowest-priority link blocks the drop, no other link is taken
    lo_v = lo_v & ~traffic_i[lo_l];
  end

  wire            pk_v = it_v | ft_v;
  wire [TW-1:0]   pk_t = it_v ? it_t : lterm_r[ft_l];
  wire            ord_dl_ok = dl_usable_i[rx_ord_dl_i] & ~dl_used[rx_ord_dl_i];
  wire            ord_new = rx_ord_v_i &&
                            lst_r[rx_ord_link_i] == lam_pkg::LK_INACT;
  // the preset list also applies in the very cycle the set request arrives
  wire            use_pre = setact_r | (setact_i & (n_act == '0));
  wire            ack_cur = rx_ack_v_i && rx_ack_link_i == cur_r;
  wire            ord_cur = rx_ord_v_i && rx_ord_link_i == cur_r;
  wire            own_hi = own_pc_i > remote_pc_i;
  wire            lend_room = n_trm > min_terms_i;
  wire            lend_busy = |lent_r;
  wire            t_out = tmr_r == lam_pkg::CW'(RETRY_CYC - 1);
  wire [DW-1:0]   act_dl = predef_dl_i[nxt_r*DW +: DW];
  wire [DW-1:0]   pre_dl = predef_dl_i[na_l*DW +: DW];
  wire            go_rest = st_r == lam_pkg::S_IDLE && !rx_ord_v_i && fp_v &&
                            lst_r[fp_l] == lam_pkg::LK_ACTIVE;

  always_comb
  begin
    st_nxt = st_r; lst_nxt = lst_r; lterm_nxt = lterm_r; ldl_nxt = ldl_r;
    ltv_nxt = ltv_r; ldv_nxt = ldv_r; cur_nxt = cur_r; nxt_nxt = nxt_r;
    tried_nxt = tried_r; tmr_nxt = tmr_r + 1'b1;
    fp_nxt = fp_r | link_fail_i;
    lent_nxt = donate_done_i ? '0 : lent_r;
    setact_nxt = setact_r | (setact_i & n_act == '0);
    tx_v_nxt = 1'b0; tx_kind_nxt = tx_kind_o; tx_res_nxt = tx_res_o;
    tx_link_nxt = tx_link_o; tx_dl_nxt = tx_dl_o;
    gnt_nxt = 1'b0; dterm_nxt = donate_term_o; align_nxt = '0;
    if (setact_i && n_act == '0) nxt_nxt = '0;
    case (st_r)
      lam_pkg::S_IDLE:
      begin
        if (rx_ord_v_i)
        begin
          if (ord_new)
          begin
            tx_v_nxt = 1'b1; tx_kind_nxt = lam_pkg::MSG_ACK;
            tx_link_nxt = rx_ord_link_i; tx_dl_nxt = rx_ord_dl_i;
            if (!pk_v) tx_res_nxt = lam_pkg::RES_NOALT;
            else if (!ord_dl_ok) tx_res_nxt = lam_pkg::RES_ALT;
            else
            begin
              tx_res_nxt = lam_pkg::RES_OK;
              if (!it_v)
              begin
                lst_nxt[ft_l] = lam_pkg::LK_INACT;
                ltv_nxt[ft_l] = 1'b0;
                ldv_nxt[ft_l] = 1'b0;
              end
              lterm_nxt[rx_ord_link_i] = pk_t; ltv_nxt[rx_ord_link_i] = 1'b1;
              ldl_nxt[rx_ord_link_i] = rx_ord_dl_i;
              ldv_nxt[rx_ord_link_i] = 1'b1;
              align_nxt[rx_ord_link_i] = 1'b1; cur_nxt = rx_ord_link_i;
              tried_nxt = 1'b0; st_nxt = lam_pkg::S_ALIGN;
            end
          end
        end
        else if (fp_v)
        begin
          fp_nxt[fp_l] = link_fail_i[fp_l];
          if (go_rest)
          begin
            lst_nxt[fp_l] = lam_pkg::LK_FAILED; align_nxt[fp_l] = 1'b1;
            cur_nxt = fp_l; tried_nxt = 1'b0; st_nxt = lam_pkg::S_ALIGN;
          end
        end
        else if (donate_req_i && !lend_busy && ft_v && lend_room)
        begin
          lent_nxt[lterm_r[ft_l]] = 1'b1; gnt_nxt = 1'b1;
          dterm_nxt = lterm_r[ft_l]; ltv_nxt[ft_l] = 1'b0;
          ldv_nxt[ft_l] = 1'b0; lst_nxt[ft_l] = lam_pkg::LK_INACT;
        end
        else if (n_act > active_target_i && lo_v)
        begin
          lst_nxt[lo_l] = lam_pkg::LK_INACT;
          ltv_nxt[lo_l] = 1'b0;
          ldv_nxt[lo_l] = 1'b0;
        end
        // only reached with no restoration running or pending
        else if (n_act < active_target_i && na_v && pk_v &&
                 (use_pre || fd_v))
        begin
          if (!it_v)
          begin
            lst_nxt[ft_l] = lam_pkg::LK_INACT;
            ltv_nxt[ft_l] = 1'b0;
            ldv_nxt[ft_l] = 1'b0;
          end
          lterm_nxt[na_l] = pk_t; ltv_nxt[na_l] = 1'b1;
          ldl_nxt[na_l] = use_pre ? pre_dl : fd_d;
          ldv_nxt[na_l] = 1'b1;
          tx_v_nxt = 1'b1; tx_kind_nxt = lam_pkg::MSG_ORDER;
          tx_link_nxt = na_l; tx_dl_nxt = use_pre ? pre_dl : fd_d;
          cur_nxt = na_l; nxt_nxt = LW'(na_l + 1'b1); tried_nxt = 1'b0;
          tmr_nxt = '0; st_nxt = lam_pkg::S_WAIT;
        end
      end
      lam_pkg::S_WAIT:
      begin
        if (ack_cur)
        begin
          if (rx_ack_res_i == lam_pkg::RES_OK)
          begin
            align_nxt[cur_r] = 1'b1; st_nxt = lam_pkg::S_ALIGN;
          end
          else if (rx_ack_res_i == lam_pkg::RES_ALT && fd_v)
          begin
            ldl_nxt[cur_r] = fd_d; tx_v_nxt = 1'b1;
            tx_kind_nxt = lam_pkg::MSG_ORDER; tx_dl_nxt = fd_d; tmr_nxt = '0;
          end
          else
          begin
            lst_nxt[cur_r] = lam_pkg::LK_INACT; ltv_nxt[cur_r] = 1'b0;
            ldv_nxt[cur_r] = 1'b0; st_nxt = lam_pkg::S_IDLE;
          end
        end
        else if (ord_cur)
        begin
          if (!own_hi)
          begin
            ldl_nxt[cur_r] = rx_ord_dl_i; tx_v_nxt = 1'b1;
            tx_kind_nxt = lam_pkg::MSG_ACK; tx_res_nxt = lam_pkg::RES_OK;
            tx_dl_nxt = rx_ord_dl_i; align_nxt[cur_r] = 1'b1;
            st_nxt = lam_pkg::S_ALIGN;
          end
        end
        // orders for other links are dropped; the far end will repeat them
        else if (!rx_ord_v_i && t_out)
        begin
          tx_v_nxt = 1'b1; tx_kind_nxt = lam_pkg::MSG_ORDER; tmr_nxt = '0;
        end
      end
      default:
      begin
        if (align_ok_i[cur_r])
        begin
          lst_nxt[cur_r] = lam_pkg::LK_ACTIVE; setact_nxt = 1'b0;
          st_nxt = lam_pkg::S_IDLE;
        end
        else if (align_fail_i[cur_r])
        begin
          if (fd_v)
          begin
            ldl_nxt[cur_r] = fd_d; tx_v_nxt = 1'b1;
            tx_kind_nxt = lam_pkg::MSG_ORDER; tx_link_nxt = cur_r;
            tx_dl_nxt = fd_d; tmr_nxt = '0; st_nxt = lam_pkg::S_WAIT;
          end
          else if (!tried_r && it_v)
          begin
            lterm_nxt[cur_r] = it_t; tried_nxt = 1'b1;
            align_nxt[cur_r] = 1'b1;
          end
          else
          begin
            lst_nxt[cur_r] = lam_pkg::LK_FAILED; st_nxt = lam_pkg::S_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      st_r <= lam_pkg::S_IDLE; lst_r <= '{default: lam_pkg::LK_INACT};
      lterm_r <= '{default: '0}; ldl_r <= '{default: '0};
      ltv_r <= '0; ldv_r <= '0; fp_r <= '0; cur_r <= '0; nxt_r <= '0;
      tried_r <= 1'b0; setact_r <= 1'b0; lent_r <= '0; tmr_r <= '0;
      tx_v_o <= 1'b0; tx_kind_o <= lam_pkg::MSG_ORDER;
      tx_res_o <= lam_pkg::RES_OK; tx_link_o <= '0; tx_dl_o <= '0;
      tx_dpc_o <= '0; tx_opc_o <= '0; align_start_o <= '0;
      donate_gnt_o <= 1'b0; donate_term_o <= '0;
    end
    else
    begin
      st_r <= st_nxt; lst_r <= lst_nxt; lterm_r <= lterm_nxt;
      ldl_r <= ldl_nxt; ltv_r <= ltv_nxt; ldv_r <= ldv_nxt; fp_r <= fp_nxt;
      cur_r <= cur_nxt; nxt_r <= nxt_nxt; tried_r <= tried_nxt;
      setact_r <= setact_nxt; lent_r <= lent_nxt; tmr_r <= tmr_nxt;
      tx_v_o <= tx_v_nxt; tx_kind_o <= tx_kind_nxt; tx_res_o <= tx_res_nxt;
      tx_link_o <= tx_link_nxt; tx_dl_o <= tx_dl_nxt;
      tx_dpc_o <= remote_pc_i; tx_opc_o <= own_pc_i;
      align_start_o <= align_nxt; donate_gnt_o <= gnt_nxt;
      donate_term_o <= dterm_nxt;
    end
  end

  always_comb
  begin
    link_active_o = '0;
    for (int i = 0; i < NL; i++)
      link_active_o[i] = lst_r[i] == lam_pkg::LK_ACTIVE;
  end
  assign dl_seized_o = dl_used;
  wire unused_ok;
  assign unused_ok = ^act_dl;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_started;
    st_r == lam_pkg::S_ALIGN && align_start_o != '0;
  endsequence
  sequence s_order_out;
    tx_v_o && tx_kind_o == lam_pkg::MSG_ORDER;
  endsequence

  a_restore_align: assert property (go_rest |=> s_started)
    else $error("restoration did not start alignment");
  a_align_active: assert property (st_r == lam_pkg::S_ALIGN &&
    align_ok_i[cur_r] |=> link_active_o != $past(link_active_o))
    else $error("aligned link not marked active");
  a_alt_dl_order: assert property (st_r == lam_pkg::S_ALIGN &&
    !align_ok_i[cur_r] && align_fail_i[cur_r] && fd_v
    |=> s_order_out ##0 st_r == lam_pkg::S_WAIT)
    else $error("no alternative data link order");
  a_surplus_drop: assert property (st_r == lam_pkg::S_IDLE && !rx_ord_v_i &&
    !fp_v && !donate_req_i && n_act > active_target_i && lo_v
    |=> n_act < $past(n_act))
    else $error("surplus link not deactivated");
  a_order_ack: assert property (st_r == lam_pkg::S_IDLE && ord_new
    |=> tx_v_o && tx_kind_o == lam_pkg::MSG_ACK)
    else $error("incoming order not acknowledged");
  a_ack_align: assert property (st_r == lam_pkg::S_WAIT && ack_cur &&
    rx_ack_res_i == lam_pkg::RES_OK |=> s_started)
    else $error("good answer did not start alignment");
  a_noalt_end: assert property (st_r == lam_pkg::S_WAIT && ack_cur &&
    rx_ack_res_i == lam_pkg::RES_NOALT
    |=> st_r == lam_pkg::S_IDLE && !tx_v_o)
    else $error("refusal did not end the procedure");
  a_collide_drop: assert property (st_r == lam_pkg::S_WAIT && !rx_ack_v_i &&
    ord_cur && own_hi |=> !tx_v_o && st_r == lam_pkg::S_WAIT)
    else $error("colliding order not dropped");
  a_retry_order: assert property (st_r == lam_pkg::S_WAIT && !rx_ack_v_i &&
    !rx_ord_v_i && t_out |=> s_order_out)
    else $error("order not repeated on timeout");
  a_lend_limit: assert property (donate_gnt_o
    |-> $past(lend_room) && !$past(lend_busy))
    else $error("terminal lent below minimum");
endmodule // link_alloc_mgr
`default_nettype wire

// ---- tb/remote_point.sv ----
`timescale 1ns/1ps
`default_nettype none
module remote_point (
  input  wire logic                   clk_i,
  input  wire logic                   tx_v_i,
  input  wire lam_pkg::msg_t          tx_kind_i,
  input  wire logic [lam_pkg::LW-1:0] tx_link_i,
  input  wire logic                   ack_en_i,
  input  wire lam_pkg::res_t          ack_res_i,
  input  wire logic [3:0]             ack_dly_i,
  input  wire logic                   ord_req_i,
  input  wire logic [lam_pkg::LW-1:0] ord_link_i,
  input  wire logic [lam_pkg::DW-1:0] ord_dl_i,
  output logic                        rx_ord_v_o,
  output logic [lam_pkg::LW-1:0]      rx_ord_link_o,
  output logic [lam_pkg::DW-1:0]      rx_ord_dl_o,
  output logic                        rx_ack_v_o,
  output logic [lam_pkg::LW-1:0]      rx_ack_link_o,
  output lam_pkg::res_t               rx_ack_res_o
);
  logic [3:0]             cnt_r = 4'h0;
  logic [lam_pkg::LW-1:0] link_r = 2'h0;
  initial
  begin
    {rx_ord_v_o, rx_ord_link_o, rx_ord_dl_o, rx_ack_v_o} = 7'h00;
    rx_ack_link_o = 2'h0;
    rx_ack_res_o = lam_pkg::RES_OK;
  end
  // the far end answers with ack_res_i, whatever data link the initiator picked
  always @(posedge clk_i)
  begin
    if (tx_v_i && tx_kind_i == lam_pkg::MSG_ORDER && ack_en_i)
    begin
      cnt_r  <= ack_dly_i;
      link_r <= tx_link_i;
    end
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
    rx_ack_v_o    <= (cnt_r == 4'h1);
    rx_ack_link_o <= (cnt_r == 4'h1) ? link_r : ~rx_ack_link_o;
    // released fields toggle so a stale value is never mistaken for data
    rx_ack_res_o  <= (cnt_r == 4'h1) ? ack_res_i
                                     : lam_pkg::res_t'(~rx_ack_res_o);
    rx_ord_v_o    <= ord_req_i;
    rx_ord_link_o <= ord_req_i ? ord_link_i : ~rx_ord_link_o;
    rx_ord_dl_o   <= ord_req_i ? ord_dl_i : ~rx_ord_dl_o;
  end
endmodule // remote_point
`default_nettype wire

// ---- tb/test_link_alloc_mgr.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_link_alloc_mgr;
  localparam int RETRY = 20;
  logic                      clk_i, rst_n_i, setact_i, tx_v_o, ack_en;
  logic                      rx_ord_v_i, rx_ack_v_i, ord_req, donate_gnt_o;
  logic                      donate_req_i, donate_done_i;
  logic [lam_pkg::PCW-1:0]   own_pc_i, remote_pc_i, tx_dpc_o, tx_opc_o;
  logic [lam_pkg::LW:0]      active_target_i;
  logic [lam_pkg::TW:0]      min_terms_i;
  logic [11:0]               predef_dl_i;
  logic [lam_pkg::NLINK-1:0] link_fail_i, align_ok_i, align_fail_i, traffic_i;
  logic [lam_pkg::NLINK-1:0] align_start_o, link_active_o;
  logic [lam_pkg::NTERM-1:0] term_ok_i;
  logic [lam_pkg::NDL-1:0]   dl_usable_i, dl_seized_o;
  logic [lam_pkg::LW-1:0]    rx_ord_link_i, rx_ack_link_i, tx_link_o, ord_link;
  logic [lam_pkg::DW-1:0]    rx_ord_dl_i, tx_dl_o, ord_dl;
  logic [lam_pkg::TW-1:0]    donate_term_o;
  logic [3:0]                ack_dly;
  lam_pkg::res_t             rx_ack_res_i, tx_res_o, ack_res;
  lam_pkg::msg_t             tx_kind_o;
  int                        num_errors, samples_checked, cyc, n_msgs, d0, a0;
  int                        ack_cyc, ord_in_cyc, gnt_cyc, last_ord, prev_ord;
  int                        last_dl, align_cyc [4];
  int                        q_kind [$], q_link [$], q_dl [$], q_res [$];

  link_alloc_mgr #(.RETRY_CYC(RETRY)) dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .own_pc_i(own_pc_i), .remote_pc_i(remote_pc_i), .setact_i(setact_i),
    .active_target_i(active_target_i), .min_terms_i(min_terms_i),
    .predef_dl_i(predef_dl_i), .link_fail_i(link_fail_i),
    .align_ok_i(align_ok_i), .align_fail_i(align_fail_i),
    .traffic_i(traffic_i), .term_ok_i(term_ok_i), .dl_usable_i(dl_usable_i),
    .rx_ord_v_i(rx_ord_v_i), .rx_ord_link_i(rx_ord_link_i),
    .rx_ord_dl_i(rx_ord_dl_i), .rx_ack_v_i(rx_ack_v_i),
    .rx_ack_link_i(rx_ack_link_i), .rx_ack_res_i(rx_ack_res_i),
    .donate_req_i(donate_req_i), .donate_done_i(donate_done_i),
    .tx_v_o(tx_v_o), .tx_kind_o(tx_kind_o), .tx_dpc_o(tx_dpc_o),
    .tx_opc_o(tx_opc_o), .tx_link_o(tx_link_o), .tx_dl_o(tx_dl_o),
    .tx_res_o(tx_res_o), .align_start_o(align_start_o),
    .link_active_o(link_active_o), .dl_seized_o(dl_seized_o),
    .donate_gnt_o(donate_gnt_o), .donate_term_o(donate_term_o));
  remote_point peer (.clk_i(clk_i), .tx_v_i(tx_v_o), .tx_kind_i(tx_kind_o),
    .tx_link_i(tx_link_o), .ack_en_i(ack_en), .ack_res_i(ack_res),
    .ack_dly_i(ack_dly), .ord_req_i(ord_req), .ord_link_i(ord_link),
    .ord_dl_i(ord_dl), .rx_ord_v_o(rx_ord_v_i), .rx_ord_link_o(rx_ord_link_i),
    .rx_ord_dl_o(rx_ord_dl_i), .rx_ack_v_o(rx_ack_v_i),
    .rx_ack_link_o(rx_ack_link_i), .rx_ack_res_o(rx_ack_res_i));

  task automatic tally_and_finish();
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic fail(string m);
    num_errors++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task automatic chk_val(logic [15:0] got, logic [15:0] want, string m);
    samples_checked++;
    if (got !== want)
      fail(m);
  endtask
  // reference model: queue of the messages the far end should see next
  task automatic expect_msg(int k, int l, int d, int r);
    q_kind.push_back(k);
    q_link.push_back(l);
    q_dl.push_back(d);
    q_res.push_back(r);
  endtask
  task automatic chk_msg();
    int k, l, d, r;
    bit bad;
    n_msgs++;
    samples_checked++;
    if (q_kind.size() == 0)
    begin
      fail("unexpected message");
      return;
    end
    k = q_kind.pop_front();
    l = q_link.pop_front();
    d = q_dl.pop_front();
    r = q_res.pop_front();
    bad = tx_kind_o !== lam_pkg::msg_t'(k) || tx_link_o !== 2'(l);
    bad |= tx_dpc_o !== remote_pc_i || tx_opc_o !== own_pc_i;
    if (d >= 0)
      bad |= tx_dl_o !== 3'(d);
    if (d == -2)
      bad |= tx_dl_o === 3'(last_dl);
    if (r >= 0)
      bad |= tx_res_o !== lam_pkg::res_t'(r);
    if (bad)
      fail("message fields differ");
    if (k == 0)
    begin
      prev_ord = last_ord;
      last_ord = cyc;
      last_dl = tx_dl_o;
    end
  endtask
  task automatic wait_msgs(int n);
    for (int w = 0; w < 200 && n_msgs < n; w++)
      @(negedge clk_i);
    chk_val(16'(n_msgs >= n), 16'h1, "message missing");
  endtask
  task automatic wait_align(int l, int after);
    for (int w = 0; w < 50 && align_cyc[l] <= after; w++)
      @(negedge clk_i);
    chk_val(16'(align_cyc[l] > after), 16'h1, "no alignment start");
  endtask
  task automatic send_ord(int l, int d);
    @(posedge clk_i);
    ord_req  <= 1'b1;
    ord_link <= 2'(l);
    ord_dl   <= 3'(d);
    @(posedge clk_i);
    ord_req  <= 1'b0;
  endtask
  task automatic pulse_ok(int l);
    @(posedge clk_i);
    align_ok_i <= 4'h1 << l;
    @(posedge clk_i);
    align_ok_i <= 4'h0;
    @(negedge clk_i);
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // the ceiling sits far above the 150-odd cycles the tests need
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      tally_and_finish();
    end
    if (rx_ack_v_i === 1'b1)
      ack_cyc = cyc;
    if (rx_ord_v_i === 1'b1)
      ord_in_cyc = cyc;
    if (donate_gnt_o === 1'b1)
      gnt_cyc = cyc;
    for (int l = 0; l < 4; l++)
      if (align_start_o[l] === 1'b1)
        align_cyc[l] = cyc;
    if (tx_v_o === 1'b1)
      chk_msg();
  end

  initial
  begin
    {num_errors, samples_checked, cyc, n_msgs, last_dl} = '0;
    {ack_cyc, ord_in_cyc, gnt_cyc, last_ord, prev_ord} = {5{-1}};
    align_cyc = '{-1, -1, -1, -1};
    d0 = $urandom(32'hcba5);
    own_pc_i = 14'($urandom);
    remote_pc_i = own_pc_i + 14'($urandom_range(1, 999));
    predef_dl_i = 12'($urandom);
    {rst_n_i, setact_i, donate_req_i, donate_done_i, ack_en, ord_req} = '0;
    {active_target_i, link_fail_i, align_ok_i, align_fail_i, traffic_i} = '0;
    {ord_link, ord_dl, ack_dly} = '0;
    ack_res = lam_pkg::RES_OK;
    min_terms_i = 3'h2;
    term_ok_i = 4'hf;
    dl_usable_i = 8'hff;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    chk_val(16'({link_active_o, dl_seized_o, tx_v_o}), 16'h0, "reset state");
    d0 = predef_dl_i[2:0];
    repeat (3) expect_msg(0, 0, d0, -1);
    @(posedge clk_i);
    active_target_i <= 3'h1;
    setact_i <= 1'b1;
    @(posedge clk_i);
    setact_i <= 1'b0;
    wait_msgs(2);
    chk_val(16'(last_ord - prev_ord), 16'(RETRY), "retry spacing");
    chk_val(16'(dl_seized_o[d0]), 16'h1, "data link not seized");
    @(posedge clk_i);
    {ack_en, ack_dly} <= {1'b1, 4'h3};
    wait_msgs(3);
    chk_val(16'(last_ord - prev_ord), 16'(RETRY), "retry spacing");
    wait_align(0, -1);
    chk_val(16'(align_cyc[0] - ack_cyc), 16'h1, "align after ack");
    pulse_ok(0);
    chk_val(16'(link_active_o), 16'h1, "link 0 not active");
    send_ord(0, 1);
    @(posedge clk_i);
    donate_req_i <= 1'b1;
    @(posedge clk_i);
    donate_req_i <= 1'b0;
    repeat (6) @(negedge clk_i);
    chk_val(16'(gnt_cyc), 16'hffff, "terminal lent");
    chk_val(16'(link_active_o), 16'h1, "order for active link");
    traffic_i <= 4'h2;
    expect_msg(1, 1, -1, 0);
    send_ord(1, d0 ^ 1);
    wait_align(1, -1);
    chk_val(16'(align_cyc[1] - ord_in_cyc), 16'h1, "align on order");
    chk_val(16'(dl_seized_o[d0 ^ 1]), 16'h1, "named link free");
    pulse_ok(1);
    repeat (10) @(negedge clk_i);
    chk_val(16'(link_active_o), 16'h3, "busy link dropped");
    traffic_i <= 4'h0;
    repeat (6) @(negedge clk_i);
    chk_val(16'(link_active_o), 16'h1, "surplus link kept");
    chk_val(16'(dl_seized_o[d0 ^ 1]), 16'h0, "data link kept");
    a0 = align_cyc[0];
    @(posedge clk_i);
    link_fail_i <= 4'h1;
    @(posedge clk_i);
    link_fail_i <= 4'h0;
    wait_align(0, a0);
    pulse_ok(0);
    chk_val(16'(link_active_o[0]), 16'h1, "link 0 not restored");
    expect_msg(0, 1, -1, -1);
    expect_msg(0, 1, -2, -1);
    ack_res <= lam_pkg::RES_ALT;
    active_target_i <= 3'h2;
    wait_msgs(n_msgs + 2);
    @(posedge clk_i);
    ack_res <= lam_pkg::RES_NOALT;
    active_target_i <= 3'h1;
    a0 = n_msgs;
    repeat (40) @(negedge clk_i);
    chk_val(16'(n_msgs - a0), 16'h0, "procedure not ended");
    ack_en <= 1'b0;
    expect_msg(0, 2, -1, -1);
    active_target_i <= 3'h2;
    wait_msgs(n_msgs + 1);
    a0 = align_cyc[2];
    if (own_pc_i < remote_pc_i)
      expect_msg(1, 2, -1, 0);
    send_ord(2, d0 ^ 2);
    repeat (4) @(negedge clk_i);
    chk_val(16'(align_cyc[2] > a0), 16'(own_pc_i < remote_pc_i), "collision");
    chk_val(16'(q_kind.size()), 16'h0, "answer missing");
    tally_and_finish();
  end
endmodule // test_link_alloc_mgr
`default_nettype wire
